// >>> src/epc_consts.svh
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH
// register word indices (io offsets 0x000..0x404); the bus byte address is four times these
`define EPC_IDX_ADDR_Q    12'h000
`define EPC_IDX_DATA      12'h000
`define EPC_IDX_STATUS    12'h001
`define EPC_IDX_CONTROL   12'h002
`define EPC_IDX_FIFO      12'h400
`define EPC_IDX_CFGA      12'h400
`define EPC_IDX_CFGB      12'h401
`define EPC_IDX_EMC       12'h402
`define EPC_IDX_THRESH    12'h403
`define EPC_IDX_DMA       12'h404
// field positions
`define EPC_EMC_FAULT_MASK 4
`define EPC_EMC_DMA_EN     3
`define EPC_EMC_SERVICE    2
`define EPC_EMC_FULL       1
`define EPC_EMC_EMPTY      0
`define EPC_DCR_DIR        5
// reset and fixed values
`define EPC_CFGA_VALUE     8'h10
`define EPC_EMC_RESET      8'h15
`define EPC_DCR_RESET      8'h00
`define EPC_THRESH_RESET   8'h88
`define EPC_CFGB_LOW       3'h7
`define EPC_AXI_OKAY       2'h0
`define EPC_AXI_SLVERR     2'h2
// handshake timing
`define EPC_SETUP_NS       80
`define EPC_SETUP_CYC      ((`EPC_SETUP_NS + 39) / 40)
`define EPC_FIFO_DEPTH     16
`endif

// >>> src/epc_pkg.sv
package epc_pkg;
  // port modes held in the top three bits of the extended control register
  typedef enum logic [2:0]
  {
    EPC_MODE_STD = 3'h0,
    EPC_MODE_BIDIR = 3'h1,
    EPC_MODE_FIFO = 3'h2,
    EPC_MODE_ECP = 3'h3,
    EPC_MODE_EPP = 3'h4,
    EPC_MODE_RSVD = 3'h5,
    EPC_MODE_TEST = 3'h6,
    EPC_MODE_CFG = 3'h7
  } epc_mode_t;
  // link engine states
  typedef enum logic [2:0]
  {
    EPC_ST_IDLE,
    EPC_ST_SETUP,
    EPC_ST_STROBE,
    EPC_ST_RELEASE,
    EPC_ST_REV_REQ,
    EPC_ST_REV_WAIT
  } epc_state_t;
endpackage

// >>> src/epc_port.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "epc_consts.svh"
module epc_port
  import epc_pkg::*;
#(
  parameter int DEPTH = `EPC_FIFO_DEPTH,
  parameter logic [2:0] IRQ_CODE = 3'h0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_line_level,
  input wire logic dma_terminal_count,
  output logic dma_request,
  output logic service_irq,
  output logic fault_irq,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe,
  output logic nstrobe,
  output logic nautofd,
  output logic ninit,
  output logic nselectin,
  input wire logic busy,
  input wire logic nack,
  input wire logic perror,
  input wire logic select,
  input wire logic nfault
);
  initial
  begin
    if (DEPTH != 16)
      $error("epc_port: fifo depth must be 16");
  end

  // ****************************************************************
  // registers and fifo storage
  // ****************************************************************
  logic [7:0] emc_reg;              // mode, mask, dma, service
  logic [7:0] dcr_reg;              // control lines and direction
  logic [7:0] data_reg;             // latched data port value
  logic [7:0] thresh_reg;           // [7:4] write, [3:0] read threshold
  logic [7:0] fifo_mem [DEPTH];     // shared byte storage
  logic [DEPTH-1:0] fifo_tag;       // 1 marks a command byte
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [4:0] count_reg;            // bytes held
  epc_state_t state_reg;
  logic [3:0] wait_reg;             // setup counter
  logic [7:0] out_byte_reg;         // byte on the lines
  logic out_cmd_reg;                // its command tag
  logic nfault_d_reg;               // for edge detect
  logic fault_irq_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [13:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] bresp_reg;

  // ****************************************************************
  // decode
  // ****************************************************************
  epc_mode_t mode;
  assign mode = epc_mode_t'(emc_reg[7:5]);
  wire dir_in = dcr_reg[`EPC_DCR_DIR] && mode != EPC_MODE_STD && mode != EPC_MODE_FIFO;
  wire fifo_full = count_reg == 5'(DEPTH);
  wire fifo_empty = count_reg == 5'h0;
  wire service_set = emc_reg[`EPC_EMC_SERVICE];
  wire dma_en = emc_reg[`EPC_EMC_DMA_EN];
  wire fwd_link = (mode == EPC_MODE_FIFO || mode == EPC_MODE_ECP) && !dir_in;
  wire rev_link = mode == EPC_MODE_ECP && dir_in;
  wire cfg_mode = mode == EPC_MODE_CFG;
  wire fifo_mode = mode == EPC_MODE_FIFO || mode == EPC_MODE_ECP || mode == EPC_MODE_TEST;
  wire [4:0] free_bytes = 5'(DEPTH) - count_reg;

  // write path: both channels held, then acted on once
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [11:0] wr_idx = awaddr_reg[13:2];
  wire [7:0] wbyte = wdata_reg[7:0];
  wire wlane = 1'b1;
  wire wr_data_port = wr_go && wr_idx == `EPC_IDX_DATA;
  wire wr_addr_q = wr_data_port && mode == EPC_MODE_ECP && !dir_in;
  wire wr_fifo_q = wr_go && wr_idx == `EPC_IDX_FIFO && fifo_mode && !cfg_mode;
  wire wr_cfgb = wr_go && wr_idx == `EPC_IDX_CFGB && cfg_mode;
  wire wr_emc = wr_go && wr_idx == `EPC_IDX_EMC;
  wire wr_dcr = wr_go && wr_idx == `EPC_IDX_CONTROL;
  wire wr_thr = wr_go && wr_idx == `EPC_IDX_THRESH;
  wire wr_known = wr_data_port || wr_go && (wr_idx == `EPC_IDX_FIFO || wr_idx == `EPC_IDX_EMC
                  || wr_idx == `EPC_IDX_CONTROL || wr_idx == `EPC_IDX_THRESH);
  wire push_sw = (wr_addr_q || wr_fifo_q) && !fifo_full && wlane;

  // read path
  wire rd_go = s_axi_arvalid && !rvalid_reg;
  wire [11:0] rd_idx = s_axi_araddr[13:2];
  wire rd_fifo = rd_go && rd_idx == `EPC_IDX_FIFO && !cfg_mode
                 && (mode == EPC_MODE_TEST || rev_link);
  wire [7:0] cfgb_val = {1'b0, irq_line_level, IRQ_CODE, `EPC_CFGB_LOW};
  wire [7:0] emc_val = {emc_reg[7:2], fifo_full, fifo_empty};
  wire [7:0] status_val = {~busy, nack, perror, select, nfault, 3'h7};
  wire [7:0] data_val = (mode == EPC_MODE_BIDIR) ? pd_in : data_reg;
  wire [7:0] fifo_head = fifo_mem[rd_ptr_reg];
  logic [8:0] rd_val;               // {valid, byte}
  always_comb
  begin
    rd_val = 9'h000;
    unique case (rd_idx)
      `EPC_IDX_DATA: rd_val = {1'b1, data_val};
      `EPC_IDX_STATUS: rd_val = {1'b1, status_val};
      `EPC_IDX_CONTROL: rd_val = {1'b1, 2'h3, dcr_reg[5:0]};
      `EPC_IDX_FIFO: rd_val = cfg_mode ? {1'b1, `EPC_CFGA_VALUE} : {1'b1, fifo_head};
      `EPC_IDX_CFGB: rd_val = cfg_mode ? {1'b1, cfgb_val} : 9'h000;
      `EPC_IDX_EMC: rd_val = {1'b1, emc_val};
      `EPC_IDX_THRESH: rd_val = {1'b1, thresh_reg};
      default: rd_val = 9'h000;
    endcase
  end

  // ****************************************************************
  // link engine helpers
  // ****************************************************************
  wire fifo_reset = mode == EPC_MODE_STD;
  wire link_pop = state_reg == EPC_ST_IDLE && fwd_link && !fifo_empty && !busy;
  wire rev_push = state_reg == EPC_ST_REV_WAIT && !nack && !fifo_full;
  wire push = push_sw || rev_push;
  wire pop = rd_fifo && !fifo_empty || link_pop;
  wire push_tag = wr_addr_q;

  // mode change legality
  wire [2:0] new_mode = wbyte[7:5];
  wire mode_ok = mode == EPC_MODE_STD || mode == EPC_MODE_BIDIR
                 || new_mode == 3'h0 || new_mode == 3'h1;

  // service flag sources
  wire thr_hit = dir_in ? count_reg >= {1'b0, thresh_reg[3:0]}
                        : free_bytes >= {1'b0, thresh_reg[7:4]};
  wire svc_event = !service_set && fifo_mode && (dma_en ? dma_terminal_count : thr_hit);
  wire fault_fall = nfault_d_reg && !nfault;

  // ****************************************************************
  // extended mode control register
  // ****************************************************************
  logic [7:0] emc_next;
  always_comb
  begin
    emc_next = emc_reg;
    if (wr_emc)
    begin
      // software may clear the service flag; a set from hardware wins below
      emc_next[4:2] = wbyte[4:2];
      if (mode_ok)
        emc_next[7:5] = new_mode;
    end
    if (svc_event)
      emc_next[`EPC_EMC_SERVICE] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      emc_reg <= `EPC_EMC_RESET;
    else
      emc_reg <= emc_next;
  end

  // ****************************************************************
  // control, data and threshold registers
  // ****************************************************************
  wire dir_ok = mode == EPC_MODE_BIDIR;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dcr_reg <= `EPC_DCR_RESET;
      data_reg <= 8'h00;
      thresh_reg <= `EPC_THRESH_RESET;
    end
    else
    begin
      if (wr_dcr)
        dcr_reg <= {2'h3, dir_ok ? wbyte[5] : dcr_reg[5], wbyte[4:0]};
      if (wr_data_port && !wr_addr_q)
        data_reg <= wbyte;
      if (wr_thr)
        thresh_reg <= wbyte;
    end
  end

  // ****************************************************************
  // shared fifo
  // ****************************************************************
  // one store serves every queue view; tag keeps address bytes apart
  wire [7:0] push_byte = rev_push ? pd_in : wbyte;
  wire push_cmd = rev_push ? !busy : push_tag;
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      fifo_mem[wr_ptr_reg] <= push_byte;
      fifo_tag[wr_ptr_reg] <= push_cmd;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || fifo_reset)
    begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      count_reg <= count_reg + 5'(push) - 5'(pop);
    end
  end

  // ****************************************************************
  // link state machine
  // ****************************************************************
  // forward: idle -> setup -> strobe until busy -> release until !busy
  // reverse: ninit low, wait perror low, then nautofd/nack per byte
  epc_state_t state_next;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      EPC_ST_IDLE:
        if (link_pop)
          state_next = EPC_ST_SETUP;
        else if (rev_link)
          state_next = EPC_ST_REV_REQ;
      EPC_ST_SETUP:
        if (wait_reg == 4'(`EPC_SETUP_CYC))
          state_next = EPC_ST_STROBE;
      EPC_ST_STROBE:
        if (busy)
          state_next = EPC_ST_RELEASE;
      EPC_ST_RELEASE:
        if (!busy)
          state_next = EPC_ST_IDLE;
      EPC_ST_REV_REQ:
        if (!rev_link)
          state_next = EPC_ST_IDLE;
        else if (!perror)
          state_next = EPC_ST_REV_WAIT;
      EPC_ST_REV_WAIT:
        if (rev_push || !rev_link)
          state_next = EPC_ST_REV_REQ;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= EPC_ST_IDLE;
      wait_reg <= 4'h0;
      out_byte_reg <= 8'h00;
      out_cmd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= (state_reg == EPC_ST_SETUP) ? wait_reg + 4'h1 : 4'h0;
      if (link_pop)
      begin
        out_byte_reg <= fifo_head;
        out_cmd_reg <= fifo_tag[rd_ptr_reg] && mode == EPC_MODE_ECP;
      end
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  wire auto_hs = fwd_link || rev_link;
  wire rev_phase = state_reg == EPC_ST_REV_REQ || state_reg == EPC_ST_REV_WAIT;
  assign pd_out = (state_reg == EPC_ST_IDLE && !auto_hs) ? data_reg : out_byte_reg;
  // the reverse acknowledge only gates the drivers in ecp mode; modes 000/010 always drive
  assign pd_oe = !dir_in && !rev_phase && (perror || mode != EPC_MODE_ECP);
  assign nstrobe = auto_hs ? state_reg != EPC_ST_STROBE : !dcr_reg[0];
  assign nautofd = rev_link ? state_reg != EPC_ST_REV_WAIT
                 : (mode == EPC_MODE_ECP ? !out_cmd_reg : !dcr_reg[1]);
  assign ninit = rev_link ? 1'b0 : dcr_reg[2];
  assign nselectin = !dcr_reg[3];

  // ****************************************************************
  // dma and interrupts
  // ****************************************************************
  wire dma_want = dir_in ? !fifo_empty : !fifo_full;
  assign dma_request = dma_en && !service_set && fifo_mode && dma_want;
  assign service_irq = service_set && !dma_en; // also raised by a software write of 1 to the service bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nfault_d_reg <= 1'b1;
      fault_irq_reg <= 1'b0;
    end
    else
    begin
      nfault_d_reg <= nfault;
      fault_irq_reg <= fault_fall && mode == EPC_MODE_ECP && !emc_reg[`EPC_EMC_FAULT_MASK];
    end
  end
  assign fault_irq = fault_irq_reg;

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  // one write and one read at a time; unmapped gives slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 14'h0000;
      wdata_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= `EPC_AXI_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `EPC_AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_known || wr_cfgb) ? `EPC_AXI_OKAY : `EPC_AXI_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
      if (rd_go)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_val[7:0]};
        rresp_reg <= rd_val[8] ? `EPC_AXI_OKAY : `EPC_AXI_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule

// >>> testbench/epc_periph.sv
`timescale 1ns/100ps
// ************************
// peripheral on the cable
// ************************
module epc_periph
  import epc_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  input wire logic nstrobe,
  input wire logic nautofd,
  input wire logic ninit,
  input wire logic [3:0] lag,
  output logic [7:0] pd_in,
  output logic busy,
  output logic nack,
  output logic perror,
  output logic select
);
  logic [7:0] drv = 8'h00; // our drive, inverted once let go
  logic on = 1'b0; // we hold a reverse byte
  logic [3:0] cnt = 4'h0; // slow-answer countdown
  logic [8:0] fwd_q[$]; // {command, byte} as latched
  logic [7:0] rev_q[$]; // bytes to send back
  // wire level: host drive wins, else ours
  assign pd_in = pd_oe ? pd_out : drv;
  initial
  begin
    busy = 1'b0;
    nack = 1'b1;
    perror = 1'b1;
    select = 1'b1;
  end
  // forward latch on strobe, reverse byte by byte
  always @(posedge aclk)
  begin
    perror <= ninit;
    if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (ninit && !nstrobe && !busy)
    begin
      fwd_q.push_back({!nautofd, pd_out});
      busy <= 1'b1;
      cnt <= lag;
    end
    else if (ninit && nstrobe && busy)
    begin
      busy <= 1'b0;
      cnt <= lag;
    end
    if (!ninit && !perror && !nautofd && nack && !on && rev_q.size() > 0)
    begin
      drv <= rev_q.pop_front();
      on <= 1'b1;
      busy <= 1'b1;
    end
    else if (on && nack && !nautofd)
      nack <= 1'b0;
    else if (nautofd && !nack)
    begin
      nack <= 1'b1;
      on <= 1'b0;
      drv <= ~drv;
    end
  end
endmodule

// >>> testbench/epc_port_chk.sv
`timescale 1ns/100ps
// ************************
// port-side checker
// ************************
module epc_port_chk
  import epc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  input wire logic nstrobe,
  input wire logic nautofd,
  input wire logic ninit,
  input wire logic busy,
  input wire logic perror,
  input wire logic nfault,
  input wire logic fault_irq,
  input wire logic dma_request,
  input wire logic service_irq,
  input wire logic dma_terminal_count
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // strobe out and the peripheral has answered
  sequence s_stb_busy;
    !nstrobe && busy;
  endsequence
  // reverse requested and a byte asked for
  sequence s_rev_req;
    !ninit && !nautofd;
  endsequence
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_stb_data;
    !nstrobe && !$past(nstrobe) |-> pd_oe && $stable(pd_out);
  endproperty
  a_stb_data: assert property (p_stb_data) else $error("data moved under strobe");
  property p_stb_wait;
    !nstrobe && !busy |=> !nstrobe;
  endproperty
  a_stb_wait: assert property (p_stb_wait) else $error("strobe left before busy");
  property p_stb_rel;
    s_stb_busy |-> ##[1:3] nstrobe;
  endproperty
  a_stb_rel: assert property (p_stb_rel) else $error("strobe stuck after busy");
  property p_rev_drive;
    s_rev_req |-> !pd_oe;
  endproperty
  a_rev_drive: assert property (p_rev_drive) else $error("data driven in reverse");
  property p_rev_ack;
    !ninit && $fell(nautofd) |-> !perror;
  endproperty
  a_rev_ack: assert property (p_rev_ack) else $error("byte asked before ack");
  property p_fault;
    fault_irq |-> (!$past(nfault) && $past(nfault, 2)) ##1 !fault_irq;
  endproperty
  a_fault: assert property (p_fault) else $error("fault pulse off its edge");
  property p_dma_excl;
    service_irq |-> !dma_request;
  endproperty
  a_dma_excl: assert property (p_dma_excl) else $error("dma with service set");
  property p_tc;
    dma_request && dma_terminal_count |=> !dma_request;
  endproperty
  a_tc: assert property (p_tc) else $error("dma kept after count");
endmodule

// >>> testbench/epc_port_tb.sv
`timescale 1ns/100ps
// ************************
// port bench
// ************************
module epc_port_tb
  import epc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1, lag = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic irq_line_level = 1'b1, dma_terminal_count = 1'b0, nfault = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_request, service_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pd_in, pd_out;
  logic fault_irq, pd_oe, nstrobe, nautofd, ninit, nselectin, busy, nack, perror, select;
  int failures = 0, tests_run = 0, fault_cnt = 0;
  // register reads in config mode: {address, resp, data}
  logic [47:0] rows [7] = '{{14'h1000, 2'h0, 32'h10}, {14'h1004, 2'h0, 32'h6f}, {14'h1008, 2'h0, 32'hf5},
    {14'h100c, 2'h0, 32'h88}, {14'h0004, 2'h0, 32'hff}, {14'h0008, 2'h0, 32'hc4}, {14'h1010, 2'h2, 32'h0}};
  epc_port #(.IRQ_CODE(3'h5)) dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq_line_level(irq_line_level), .dma_terminal_count(dma_terminal_count), .dma_request(dma_request),
    .service_irq(service_irq), .fault_irq(fault_irq), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .nstrobe(nstrobe), .nautofd(nautofd), .ninit(ninit), .nselectin(nselectin), .busy(busy), .nack(nack),
    .perror(perror), .select(select), .nfault(nfault)
  );
  epc_periph per
  (
    .aclk(aclk), .pd_out(pd_out), .pd_oe(pd_oe), .nstrobe(nstrobe), .nautofd(nautofd), .ninit(ninit),
    .lag(lag), .pd_in(pd_in), .busy(busy), .nack(nack), .perror(perror), .select(select)
  );
  always #20 aclk = ~aclk;
  // fault pulse counter
  always @(posedge aclk)
    if (fault_irq === 1'b1) fault_cnt++;
  task automatic conclude();
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write; both channels offered together
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    chk({s_axi_bresp, 31'h0, s_axi_bvalid}, 34'h1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // one read compared as {resp, data}
  task automatic rc(input logic [13:0] a, input logic [33:0] exp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    chk({s_axi_rresp, s_axi_rdata}, exp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // wait for the cable to go quiet, bounded
  task automatic settle(input int k);
    int n;
    n = 0;
    while (n < 400 && (per.fwd_q.size() < k || per.rev_q.size() > 0 || per.on || !nack || (busy && ninit)))
    begin
      @(posedge aclk);
      n++;
    end
    chk(34'(n < 400), 34'h1);
  endtask
  task automatic fault_edge();
    nfault <= 1'b0;
    repeat (4) @(posedge aclk);
    nfault <= 1'b1;
    @(posedge aclk);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(14'h1008, 34'h15);
    chk(34'(pd_oe), 34'h1);
    chk(34'(nselectin), 34'h1);
    rc(14'h1004, {2'h2, 32'h0});
    wr(14'h0008, 8'h04);
    wr(14'h1008, 8'hf4);
    foreach (rows[i]) rc(rows[i][47:34], rows[i][33:0]);
    irq_line_level <= 1'b0;
    wr(14'h1004, 8'h00);
    rc(14'h1004, 34'h2f);
    wr(14'h1008, 8'h74);
    rc(14'h1008, 34'hf5);
    wr(14'h1008, 8'h14);
    wr(14'h1008, 8'hd4);
    for (int i = 0; i < 16; i++) wr(14'h1000, 8'(i));
    rc(14'h1008, 34'hd6);
    for (int i = 0; i < 8; i++) rc(14'h1000, 34'(i));
    chk(34'(per.fwd_q.size()), 34'h0);
    wr(14'h1008, 8'h14);
    wr(14'h1008, 8'hd4);
    rc(14'h1008, 34'hd5);
    wr(14'h1008, 8'h14);
    // ecp forward with a slow peripheral
    lag <= 4'h2;
    wr(14'h1008, 8'h74);
    wr(14'h0000, 8'ha5);
    wr(14'h1000, 8'h3c);
    wr(14'h1000, 8'hc3);
    settle(3);
    chk({per.fwd_q[0], per.fwd_q[1], per.fwd_q[2]}, {9'h1a5, 9'h03c, 9'h0c3});
    wr(14'h1008, 8'h14);
    // fifo mode under dma, then terminal count
    wr(14'h1008, 8'h48);
    chk(34'(dma_request), 34'h1);
    dma_terminal_count <= 1'b1;
    @(posedge aclk);
    dma_terminal_count <= 1'b0;
    @(posedge aclk);
    chk(34'(dma_request), 34'h0);
    rc(14'h1008, 34'h4d);
    wr(14'h1000, 8'h5a);
    settle(4);
    chk(34'(per.fwd_q[3]), 34'h05a);
    wr(14'h1008, 8'h14);
    wr(14'h1008, 8'h70);
    chk(34'(service_irq), 34'h1);
    rc(14'h1008, 34'h75);
    wr(14'h1008, 8'h64);
    fault_edge();
    wr(14'h1008, 8'h74);
    fault_edge();
    chk(34'(fault_cnt), 34'h1);
    // reverse: direction set in mode 001 only
    lag <= 4'h0;
    wr(14'h1008, 8'h34);
    wr(14'h0008, 8'h24);
    per.rev_q = '{8'h11, 8'h22, 8'h33};
    wr(14'h1008, 8'h74);
    settle(0);
    for (int i = 1; i < 4; i++) rc(14'h1000, 34'(i * 17));
    wr(14'h1008, 8'h34);
    chk(34'(pd_oe), 34'h0);
    rc(14'h0000, 34'hcc);
    wr(14'h1008, 8'h14);
    chk(34'(pd_oe), 34'h1);
    conclude();
  end
  // hang guard, far beyond the run length
  initial
  begin
    #2000000;
    failures++;
    conclude();
  end
endmodule
bind epc_port epc_port_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .pd_out(pd_out), .pd_oe(pd_oe), .nstrobe(nstrobe), .nautofd(nautofd),
  .ninit(ninit), .busy(busy), .perror(perror), .nfault(nfault), .fault_irq(fault_irq),
  .dma_request(dma_request), .service_irq(service_irq), .dma_terminal_count(dma_terminal_count));
